// ==== inc/mba_pkg.sv ====
// constants and types for the master bus request attribute block
// Overview of operation
// - single unit of one to sixteen bytes uses size 0000, lanes from enables
// - cache lines use 0001 and 0010; 0011 only for slave-side third-party asks
// - burst of 128-bit units uses size 1100, count in the low lane bits
// - outgoing size may differ from the originator's, after translation
// - attribute bits 0-3 carry W, I, M, G from the translation entry
// - attribute bit 4 carries user attribute zero from the translation entry
// - attribute bit 5 carries user attribute one, optional transient hint
// - attribute bit 6 carries user attribute two, optional write allocate
// - sync attribute bit 7 holds later transfers until slave busy drops
// - during a sync transfer, slave busy is forwarded back to originator
// - attribute bit 8, the ordering hint, passes from the originator
// - attribute bits 9-15 pass unchanged from the originator
// - size and attributes stay valid while the request strobe is high
// - transfer type is always 000, a memory transfer
// - upper four address bits are always 0000
// - request strobe asks for a transfer and qualifies all fields
// - burst count in low lane bits: 0001 two units to 1111 sixteen
package mba_pkg;

  // apb register byte offsets
  localparam logic [7:0] MBA_CTRL_OFS   = 8'h00;
  localparam logic [7:0] MBA_STATUS_OFS = 8'h04;
  localparam logic [7:0] MBA_COUNT_OFS  = 8'h08;
  localparam logic [7:0] MBA_LAST_OFS   = 8'h0c;

  // control fields
  localparam int         MBA_CTRL_EN_BIT   = 0;
  localparam int         MBA_CTRL_SYNC_BIT = 1;
  localparam logic [1:0] MBA_CTRL_RESET    = 2'h3;

  // status fields
  localparam int MBA_ST_STROBE_BIT = 0;
  localparam int MBA_ST_SYNC_BIT   = 1;
  localparam int MBA_ST_BUSY_BIT   = 2;
  localparam int MBA_ST_UPERR_BIT  = 3;

  // attribute bit positions
  localparam int MBA_ATTR_TLB_BITS = 7;
  localparam int MBA_ATTR_SYNC_BIT = 7;

  // request kinds offered by the crossbar side
  localparam logic [2:0] MBA_KIND_SINGLE = 3'h0;
  localparam logic [2:0] MBA_KIND_LINE4  = 3'h1;
  localparam logic [2:0] MBA_KIND_LINE8  = 3'h2;
  localparam logic [2:0] MBA_KIND_LINE16 = 3'h3;
  localparam logic [2:0] MBA_KIND_BURST  = 3'h4;

  // size field codes
  localparam logic [3:0] MBA_SIZE_SINGLE = 4'h0;
  localparam logic [3:0] MBA_SIZE_LINE4  = 4'h1;
  localparam logic [3:0] MBA_SIZE_LINE8  = 4'h2;
  localparam logic [3:0] MBA_SIZE_LINE16 = 4'h3;
  localparam logic [3:0] MBA_SIZE_BURST  = 4'hc;

  // fixed outputs
  localparam logic [2:0] MBA_TYPE_MEMORY = 3'h0;
  localparam logic [3:0] MBA_UPPER_ZERO  = 4'h0;

  // a sixteen-word line equals four 128-bit units
  localparam logic [4:0] MBA_LINE16_UNITS = 5'h04;
  localparam logic [4:0] MBA_MIN_BURST    = 5'h02;

  typedef enum logic [1:0] {
    MBA_IDLE,
    MBA_REQ,
    MBA_SYNC
  } mba_state_t;

endpackage

// ==== src/mba_master_attr.sv ====
// master bus request attribute stage with apb control and status
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module mba_master_attr
  import mba_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W  = 16
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // request from the crossbar side
  input  wire logic              up_valid,
  output logic                   up_ready,
  input  wire logic [2:0]        up_kind,
  input  wire logic [4:0]        up_units,
  input  wire logic [15:0]       up_be,
  input  wire logic [15:0]       up_attr,
  input  wire logic [3:0]        up_upper,
  input  wire logic              up_from_cpu,
  input  wire logic              up_from_slave_port,
  input  wire logic [6:0]        cpu_tlb_attr,
  output logic                   up_busy,
  // master-side bus request
  output logic                   req_strobe,
  output logic      [3:0]        req_size_code,
  output logic      [15:0]       req_byte_lanes,
  output logic      [15:0]       req_storage_attr,
  output logic      [2:0]        req_xfer_type,
  output logic      [3:0]        req_upper_addr,
  input  wire logic              arb_addr_ack,
  input  wire logic              slave_busy_per_master
);

  mba_state_t state_reg;
  mba_state_t state_next;

  logic [1:0]       ctrl_reg;
  logic             uperr_reg;
  logic [CNT_W-1:0] count_reg;
  logic [3:0]       size_reg;
  logic [15:0]      lanes_reg;
  logic [15:0]      attr_reg;

  logic        enc_en;
  logic        sync_en;
  logic        take;
  logic        accepted;
  logic        sync_hit;
  logic [3:0]  enc_size;
  logic [15:0] enc_lanes;
  logic [15:0] attr_sel;

  logic        apb_wr;
  logic        apb_rd;
  logic        hit_ctrl;
  logic        hit_status;
  logic        hit_count;
  logic        hit_last;
  logic        hit_any;
  logic [31:0] rd_mux;
  logic        uperr_set;
  logic        uperr_clr;
  logic        in_idle;
  logic        in_req;
  logic        in_sync;
  logic        wr_ctrl;
  logic        wr_status;
  logic        wr_count;
  logic        rd_setup;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] count_word;
  logic [31:0] last_word;

  assign enc_en  = ctrl_reg[MBA_CTRL_EN_BIT];
  assign sync_en = ctrl_reg[MBA_CTRL_SYNC_BIT];

  // one flag per state for the handshake and status logic
  assign in_idle = (state_reg == MBA_IDLE);
  assign in_req  = (state_reg == MBA_REQ);
  assign in_sync = (state_reg == MBA_SYNC);

  // ------------------------------------------------------------
  // request path
  // ------------------------------------------------------------

  mba_size_enc u_size_enc (
    .kind            (up_kind),
    .units           (up_units),
    .be              (up_be),
    .from_slave_port (up_from_slave_port),
    .size_code       (enc_size),
    .lanes           (enc_lanes)
  );

  // cpu requests take the low attributes from the translation entry;
  // everything else is carried from whoever originated the request
  generate
    for (genvar i = 0; i < 16; i++) begin : g_attr
      if (i < MBA_ATTR_TLB_BITS) begin : g_tlb
        assign attr_sel[i] = up_from_cpu ? cpu_tlb_attr[i]
                                         : up_attr[i];
      end else if (i == MBA_ATTR_SYNC_BIT) begin : g_sync
        // never replaced, so any originator can ask for a sync hold
        assign attr_sel[i] = up_attr[i];
      end else begin : g_pass
        assign attr_sel[i] = up_attr[i];
      end
    end
  endgenerate

  // new work is only taken while idle, so the held request never moves
  assign up_ready = enc_en && in_idle;
  assign take     = up_valid && up_ready;
  assign accepted = in_req && arb_addr_ack;
  assign sync_hit = sync_en && attr_reg[MBA_ATTR_SYNC_BIT];

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      MBA_IDLE: begin
        if (take) begin
          state_next = MBA_REQ;
        end
      end
      MBA_REQ: begin
        if (arb_addr_ack) begin
          // a sync transfer blocks the port until the slave drops busy
          state_next = sync_hit ? MBA_SYNC : MBA_IDLE;
        end
      end
      MBA_SYNC: begin
        // limitation: the slave must show busy by the edge after the accept,
        // a later busy is not waited for
        if (!slave_busy_per_master) begin
          state_next = MBA_IDLE;
        end
      end
      default: begin
        state_next = MBA_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= MBA_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // strobe from a flop so it never glitches onto the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_strobe <= 1'b0;
    end else if (take) begin
      req_strobe <= 1'b1;
    end else if (accepted) begin
      req_strobe <= 1'b0;
    end
  end

  // fields load only on take and hold until the next take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      size_reg <= MBA_SIZE_SINGLE;
    end else if (take) begin
      size_reg <= enc_size;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lanes_reg <= 16'h0000;
    end else if (take) begin
      lanes_reg <= enc_lanes;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attr_reg <= 16'h0000;
    end else if (take) begin
      attr_reg <= attr_sel;
    end
  end

  assign req_size_code    = size_reg;
  assign req_byte_lanes   = lanes_reg;
  assign req_storage_attr = attr_reg;

  // type and upper address are constants, stable by construction
  assign req_xfer_type  = MBA_TYPE_MEMORY;
  assign req_upper_addr = MBA_UPPER_ZERO;

  // originator sees the slave busy for as long as the sync hold lasts
  assign up_busy = in_sync && slave_busy_per_master;

  // ------------------------------------------------------------
  // apb slave: zero wait states, error on unmapped offsets
  // ------------------------------------------------------------

  assign pready     = 1'b1;
  assign apb_wr     = psel && penable && pwrite;
  assign apb_rd     = psel && penable && !pwrite;
  assign hit_ctrl   = (paddr[7:0] == MBA_CTRL_OFS);
  assign hit_status = (paddr[7:0] == MBA_STATUS_OFS);
  assign hit_count  = (paddr[7:0] == MBA_COUNT_OFS);
  assign hit_last   = (paddr[7:0] == MBA_LAST_OFS);
  assign hit_any    = hit_ctrl || hit_status || hit_count || hit_last;
  assign pslverr    = psel && penable && !hit_any;

  assign wr_ctrl   = apb_wr && hit_ctrl;
  assign wr_status = apb_wr && hit_status;
  assign wr_count  = apb_wr && hit_count;
  // read data is captured in the setup cycle so prdata comes from a flop
  assign rd_setup  = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= MBA_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= pwdata[1:0];
    end
  end

  // an originator asking for nonzero upper bits is a setup fault;
  // the bits are still forced to zero on the bus
  assign uperr_set = take && (up_upper != MBA_UPPER_ZERO);
  assign uperr_clr = wr_status && pwdata[MBA_ST_UPERR_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uperr_reg <= 1'b0;
    end else if (uperr_set) begin
      // set wins over a clear in the same cycle
      uperr_reg <= 1'b1;
    end else if (uperr_clr) begin
      uperr_reg <= 1'b0;
    end
  end

  // accepted requests; wraps silently, software reads deltas
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else if (wr_count) begin
      count_reg <= '0;
    end else if (accepted) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_comb begin
    ctrl_word      = 32'h0000_0000;
    ctrl_word[1:0] = ctrl_reg;
  end

  always_comb begin
    status_word                    = 32'h0000_0000;
    status_word[MBA_ST_STROBE_BIT] = req_strobe;
    status_word[MBA_ST_SYNC_BIT]   = in_sync;
    status_word[MBA_ST_BUSY_BIT]   = slave_busy_per_master;
    status_word[MBA_ST_UPERR_BIT]  = uperr_reg;
  end

  always_comb begin
    count_word            = 32'h0000_0000;
    count_word[CNT_W-1:0] = count_reg;
  end

  // narrow lanes view: burst counts and line zeros fit in twelve bits
  assign last_word = {attr_reg, lanes_reg[11:0], size_reg};

  // offsets decode one-hot, so an unmapped offset reads as zero
  assign rd_mux = ({32{hit_ctrl}}   & ctrl_word)
                | ({32{hit_status}} & status_word)
                | ({32{hit_count}}  & count_word)
                | ({32{hit_last}}   & last_word);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// ==== src/mba_size_enc.sv ====
// size and byte-lane encoder for one outgoing request
`timescale 1ns/100ps
`default_nettype none
module mba_size_enc
  import mba_pkg::*;
(
  // request description
  input  wire logic [2:0]  kind,
  input  wire logic [4:0]  units,
  input  wire logic [15:0] be,
  input  wire logic        from_slave_port,
  // encoded fields
  output logic      [3:0]  size_code,
  output logic      [15:0] lanes
);

  logic [4:0] cnt;

  always_comb begin
    cnt       = units;
    size_code = MBA_SIZE_SINGLE;
    lanes     = be;
    unique case (kind)
      MBA_KIND_LINE4: begin
        size_code = MBA_SIZE_LINE4;
        lanes     = 16'h0000;
      end
      MBA_KIND_LINE8: begin
        size_code = MBA_SIZE_LINE8;
        lanes     = 16'h0000;
      end
      MBA_KIND_LINE16: begin
        if (from_slave_port) begin
          size_code = MBA_SIZE_LINE16;
          lanes     = 16'h0000;
        end else begin
          // others get the same line as a four-unit burst
          cnt       = MBA_LINE16_UNITS;
          size_code = MBA_SIZE_BURST;
          lanes     = {12'h000, 4'(cnt - 5'h01)};
        end
      end
      MBA_KIND_BURST: begin
        if (units < MBA_MIN_BURST) begin
          // one unit is sent as a full single transfer
          size_code = MBA_SIZE_SINGLE;
          lanes     = 16'hffff;
        end else begin
          size_code = MBA_SIZE_BURST;
          lanes     = {12'h000, 4'(cnt - 5'h01)};
        end
      end
      default: begin
        size_code = MBA_SIZE_SINGLE;
        lanes     = be;
      end
    endcase
  end

endmodule
`default_nettype wire

// ==== testbench/mba_bus_model.sv ====
// arbiter and slave model on the master-side bus
`timescale 1ns/100ps
`default_nettype none
module mba_bus_model (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // pacing set by the bench
  input wire logic [3:0]  ack_wait,
  input wire logic [3:0]  busy_len,
  // master-side bus
  input wire logic        req_strobe,
  input wire logic [15:0] req_storage_attr,
  output logic            arb_addr_ack,
  output logic            slave_busy_per_master
);
  logic [3:0] wait_cnt;
  logic [3:0] busy_cnt;
  assign slave_busy_per_master = busy_cnt != 4'h0;
  // one accept pulse per request, the strobe falls right after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      arb_addr_ack <= 1'b0;
    end else begin
      arb_addr_ack <= req_strobe && !arb_addr_ack && wait_cnt == ack_wait;
      wait_cnt <= (req_strobe && !arb_addr_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
  // posted write still draining after a sync request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 4'h0;
    end else if (arb_addr_ack && req_storage_attr[7]) begin
      busy_cnt <= busy_len;
    end else if (busy_cnt != 4'h0) begin
      busy_cnt <= busy_cnt - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/mba_master_attr_bench.sv ====
// self-checking bench for the master bus request attribute stage
`timescale 1ns/100ps
`default_nettype none
module mba_master_attr_bench;
  import mba_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        up_valid, up_ready, up_from_cpu, up_from_slave_port, up_busy;
  logic [2:0]  up_kind, req_xfer_type;
  logic [4:0]  up_units;
  logic [15:0] up_be, up_attr, req_byte_lanes, req_storage_attr;
  logic [3:0]  up_upper, req_size_code, req_upper_addr, ack_wait, busy_len;
  logic [6:0]  cpu_tlb_attr;
  logic        req_strobe, arb_addr_ack, slave_busy_per_master, rerr;
  int          err_total, total_checks, n;

  mba_master_attr DUT (
    .pclk                  (pclk),
    .presetn               (presetn),
    .paddr                 (paddr),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .up_valid              (up_valid),
    .up_ready              (up_ready),
    .up_kind               (up_kind),
    .up_units              (up_units),
    .up_be                 (up_be),
    .up_attr               (up_attr),
    .up_upper              (up_upper),
    .up_from_cpu           (up_from_cpu),
    .up_from_slave_port    (up_from_slave_port),
    .cpu_tlb_attr          (cpu_tlb_attr),
    .up_busy               (up_busy),
    .req_strobe            (req_strobe),
    .req_size_code         (req_size_code),
    .req_byte_lanes        (req_byte_lanes),
    .req_storage_attr      (req_storage_attr),
    .req_xfer_type         (req_xfer_type),
    .req_upper_addr        (req_upper_addr),
    .arb_addr_ack          (arb_addr_ack),
    .slave_busy_per_master (slave_busy_per_master)
  );
  mba_bus_model u_bus (
    .pclk                  (pclk),
    .presetn               (presetn),
    .ack_wait              (ack_wait),
    .busy_len              (busy_len),
    .req_strobe            (req_strobe),
    .req_storage_attr      (req_storage_attr),
    .arb_addr_ack          (arb_addr_ack),
    .slave_busy_per_master (slave_busy_per_master)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  // src is {from_cpu, from_slave_port}
  task automatic send(input logic [2:0] k, input logic [4:0] u,
      input logic [15:0] be, at, input logic [1:0] src,
      input logic [3:0] es, input logic [15:0] el, ea);
    @(posedge pclk);
    {up_kind, up_units, up_be, up_attr} <= {k, u, be, at};
    {up_from_cpu, up_from_slave_port, up_valid} <= {src, 1'b1};
    do @(posedge pclk); while (up_ready !== 1'b1);
    up_valid <= 1'b0;
    #1;
    chk(req_strobe, 1'b1);
    chk(req_size_code, es);
    chk(req_byte_lanes, el);
    chk(req_storage_attr, ea);
    chk(req_xfer_type, 3'h0);
    chk(req_upper_addr, 4'h0);
    do @(posedge pclk); while (req_strobe !== 1'b0);
  endtask

  task automatic t_regs;
    apb(1'b0, MBA_CTRL_OFS, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, 8'h10, 32'h0);
    chk(rerr, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, MBA_COUNT_OFS, 32'h0);
  endtask

  task automatic t_kinds;
    send(3'h0, 5'h0, 16'h00f0, 16'h0, 2'b00, 4'h0, 16'h00f0, 16'h0);
    send(3'h1, 5'h0, 16'h0, 16'h0, 2'b00, 4'h1, 16'h0, 16'h0);
    send(3'h2, 5'h0, 16'h0, 16'h0, 2'b00, 4'h2, 16'h0, 16'h0);
    send(3'h3, 5'h0, 16'h0, 16'h0, 2'b01, 4'h3, 16'h0, 16'h0);
    send(3'h3, 5'h0, 16'h0, 16'h0, 2'b00, 4'hc, 16'h3, 16'h0);
    send(3'h4, 5'h10, 16'h0, 16'h0, 2'b00, 4'hc, 16'hf, 16'h0);
    send(3'h4, 5'h2, 16'h0, 16'h0, 2'b00, 4'hc, 16'h1, 16'h0);
    send(3'h4, 5'h1, 16'h0, 16'h0, 2'b00, 4'h0, 16'hffff, 16'h0);
    apb(1'b0, MBA_COUNT_OFS, 32'h0);
    chk(rd, 32'h8);
  endtask

  // translation bits replace 0..6 only for the processor
  task automatic t_attr;
    cpu_tlb_attr <= 7'h2a;
    send(3'h0, 5'h0, 16'hffff, 16'hff00, 2'b10, 4'h0, 16'hffff,
         16'hff2a);
    send(3'h0, 5'h0, 16'h0001, 16'hff55, 2'b00, 4'h0, 16'h0001, 16'hff55);
  endtask

  task automatic t_sync;
    apb(1'b1, MBA_CTRL_OFS, 32'h0);
    #1;
    chk(up_ready, 1'b0);
    apb(1'b1, MBA_CTRL_OFS, 32'h1);
    busy_len <= 4'h6;
    send(3'h0, 5'h0, 16'h4, 16'h0080, 2'b00, 4'h0, 16'h4, 16'h0080);
    #1;
    chk(up_ready, 1'b1);
    chk(up_busy, 1'b0);
    apb(1'b1, MBA_CTRL_OFS, 32'h3);
    ack_wait <= 4'h4;
    busy_len <= 4'h6;
    send(3'h0, 5'h0, 16'h1, 16'h0080, 2'b00, 4'h0, 16'h1, 16'h0080);
    #1;
    chk(up_busy, 1'b1);
    chk(up_ready, 1'b0);
    n = 0;
    while (up_ready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk(up_ready, 1'b1);
    chk(slave_busy_per_master, 1'b0);
    ack_wait <= 4'h0;
    busy_len <= 4'h0;
  endtask

  task automatic t_upper;
    up_upper <= 4'hf;
    send(3'h0, 5'h0, 16'h2, 16'h0, 2'b00, 4'h0, 16'h2, 16'h0);
    up_upper <= 4'h0;
    apb(1'b0, MBA_STATUS_OFS, 32'h0);
    chk(rd, 32'h8);
    apb(1'b1, MBA_STATUS_OFS, 32'h8);
    apb(1'b0, MBA_STATUS_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, MBA_LAST_OFS, 32'h0);
    chk(rd, 32'h20);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, up_valid} = '0;
    {up_from_cpu, up_from_slave_port, paddr, pwdata} = '0;
    {up_kind, up_units, up_be, up_attr, up_upper, cpu_tlb_attr} = '0;
    {ack_wait, busy_len, err_total, total_checks} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_kinds;
    t_attr;
    t_sync;
    t_upper;
    end_sim;
  end

  // whole run is just over a hundred cycles
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    end_sim;
  end
endmodule
`default_nettype wire

// ==== testbench/mba_master_attr_monitor.sv ====
// assertion checker for the master bus request attribute stage
`timescale 1ns/100ps
`default_nettype none
module mba_master_attr_monitor
  import mba_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // request side
  input wire logic        up_valid,
  input wire logic        up_ready,
  input wire logic        up_busy,
  // master-side bus
  input wire logic        req_strobe,
  input wire logic [3:0]  req_size_code,
  input wire logic [15:0] req_byte_lanes,
  input wire logic [15:0] req_storage_attr,
  input wire logic [2:0]  req_xfer_type,
  input wire logic [3:0]  req_upper_addr,
  input wire logic        arb_addr_ack,
  input wire logic        slave_busy_per_master
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic sync_on;
  // mirror of the sync-hold enable, taken from control writes on the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_on <= MBA_CTRL_RESET[MBA_CTRL_SYNC_BIT];
    end else if (psel && penable && pwrite && paddr == MBA_CTRL_OFS) begin
      sync_on <= pwdata[MBA_CTRL_SYNC_BIT];
    end
  end
  AST_TYPE_MEM: assert property (req_xfer_type == 3'h0)
    else $error("transfer type not memory");
  AST_UPPER_ZERO: assert property (req_upper_addr == 4'h0)
    else $error("upper address not zero");
  AST_TAKE: assert property (up_valid && up_ready |=> req_strobe)
    else $error("accepted request gave no strobe");
  AST_HOLD: assert property (req_strobe && !arb_addr_ack |=> req_strobe)
    else $error("strobe dropped before accept");
  AST_DROP: assert property (req_strobe && arb_addr_ack |=> !req_strobe)
    else $error("strobe stayed after accept");
  AST_STABLE: assert property (req_strobe |=> $stable(req_size_code)
    && $stable(req_byte_lanes) && $stable(req_storage_attr))
    else $error("request fields moved while strobe high");
  AST_SIZE_SET: assert property (req_strobe |-> req_size_code
    inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hc}) else $error("illegal size code");
  AST_BURST: assert property (req_strobe && req_size_code == 4'hc |->
    req_byte_lanes[15:4] == 12'h0 && req_byte_lanes[3:0] != 4'h0)
    else $error("bad burst unit count");
  AST_LINE: assert property (req_strobe && req_size_code inside
    {4'h1, 4'h2, 4'h3} |-> req_byte_lanes == 16'h0) else $error("line lanes");
  AST_SYNC: assert property (req_strobe && arb_addr_ack &&
    req_storage_attr[7] && sync_on |=> !up_ready)
    else $error("sync did not block");
  AST_BUSY: assert property (up_busy |-> slave_busy_per_master
    && !up_ready) else $error("busy forward wrong");
  COV_SYNC: cover property (up_busy ##1 !up_busy);
  COV_BURST: cover property (req_strobe && req_size_code == 4'hc);
  COV_LINE16: cover property (req_strobe && req_size_code == 4'h3);
  COV_SYNC_OFF: cover property (req_strobe && arb_addr_ack &&
    req_storage_attr[7] && !sync_on);
endmodule
bind mba_master_attr mba_master_attr_monitor u_mon (
  .pclk                  (pclk),
  .presetn               (presetn),
  .psel                  (psel),
  .penable               (penable),
  .pwrite                (pwrite),
  .paddr                 (paddr),
  .pwdata                (pwdata),
  .up_valid              (up_valid),
  .up_ready              (up_ready),
  .up_busy               (up_busy),
  .req_strobe            (req_strobe),
  .req_size_code         (req_size_code),
  .req_byte_lanes        (req_byte_lanes),
  .req_storage_attr      (req_storage_attr),
  .req_xfer_type         (req_xfer_type),
  .req_upper_addr        (req_upper_addr),
  .arb_addr_ack          (arb_addr_ack),
  .slave_busy_per_master (slave_busy_per_master)
);
`default_nettype wire
